// File: rtl/cit_cfg.svh
// Timing figures and field constants for the instruction timing sequencer
`ifndef CIT_CFG_SVH
`define CIT_CFG_SVH

// ****************************************
// Bus cycle
// ****************************************
`define CIT_BUS_CLKS 2'h3
`define CIT_RETURN_PC_CYCLE 7'h03

// ****************************************
// Timing triples {clocks, reads, writes}
// ****************************************
`define CIT_ZERO {10'd0, 6'd0, 6'd0}
`define CIT_EA_IND {10'd4, 6'd1, 6'd0}
`define CIT_EA_PREDEC {10'd6, 6'd1, 6'd0}
`define CIT_EA_DISP {10'd8, 6'd2, 6'd0}
`define CIT_EA_INDEX {10'd10, 6'd2, 6'd0}
`define CIT_EA_ABSL {10'd12, 6'd3, 6'd0}
`define CIT_EA_LONG_EXTRA {10'd4, 6'd1, 6'd0}
`define CIT_SHIFT_BW {10'd6, 6'd1, 6'd0}
`define CIT_SHIFT_L {10'd8, 6'd1, 6'd0}
`define CIT_SHIFT_MEM {10'd8, 6'd1, 6'd1}
`define CIT_BIT_DYN_MEM {10'd8, 6'd1, 6'd1}
`define CIT_BIT_STAT_MEM {10'd12, 6'd2, 6'd1}
`define CIT_BIT_DYN_REG {10'd8, 6'd1, 6'd0}
`define CIT_BIT_STAT_REG {10'd12, 6'd2, 6'd0}
`define CIT_BIT_CLEAR_DYN_REG {10'd10, 6'd1, 6'd0}
`define CIT_BIT_CLEAR_STAT_REG {10'd14, 6'd2, 6'd0}
`define CIT_BR_TAKEN {10'd10, 6'd2, 6'd0}
`define CIT_BR_BYTE_NOT {10'd8, 6'd1, 6'd0}
`define CIT_BR_WORD_NOT {10'd12, 6'd2, 6'd0}
`define CIT_DB_TRUE {10'd12, 6'd2, 6'd0}
`define CIT_DB_LOOP {10'd10, 6'd2, 6'd0}
`define CIT_DB_EXPIRED {10'd14, 6'd3, 6'd0}
`define CIT_TRAP {10'd34, 6'd4, 6'd3}
`define CIT_TRAP_ON_OVERFLOW_TRAP {10'd34, 6'd5, 6'd3}
`define CIT_TRAP_ON_OVERFLOW_PASS {10'd4, 6'd1, 6'd0}
`define CIT_CHK_TRAP {10'd40, 6'd5, 6'd3}
`define CIT_CHK_PASS {10'd10, 6'd1, 6'd0}
`define CIT_JMP {10'd8, 6'd2, 6'd0}
`define CIT_JSR {10'd16, 6'd2, 6'd2}
`define CIT_LEA {10'd4, 6'd1, 6'd0}
`define CIT_PEA {10'd12, 6'd1, 6'd2}
`define CIT_MULTI_REGISTER_MOVE_TO_REG {10'd12, 6'd3, 6'd0}
`define CIT_MULTI_REGISTER_MOVE_TO_MEM {10'd8, 6'd2, 6'd0}
`define CIT_XARITH_REG_BW {10'd4, 6'd1, 6'd0}
`define CIT_XARITH_REG_L {10'd8, 6'd1, 6'd0}
`define CIT_XARITH_MEM_BW {10'd18, 6'd3, 6'd1}
`define CIT_XARITH_MEM_L {10'd30, 6'd5, 6'd2}
`define CIT_DEC_REG {10'd6, 6'd1, 6'd0}
`define CIT_DEC_MEM {10'd18, 6'd3, 6'd1}
`define CIT_RESET_INS {10'd132, 6'd1, 6'd0}
`define CIT_STOP {10'd4, 6'd0, 6'd0}
`define CIT_RETURN {10'd20, 6'd5, 6'd0}
`define CIT_CSET_FALSE {10'd4, 6'd1, 6'd0}
`define CIT_CSET_TRUE {10'd6, 6'd1, 6'd0}
`define CIT_CSET_MEM {10'd8, 6'd1, 6'd1}
`define CIT_TAS_REG {10'd4, 6'd1, 6'd0}
`define CIT_TAS_MEM {10'd10, 6'd1, 6'd1}
`define CIT_EXC_RESET {10'd34, 6'd6, 6'd0}
`define CIT_EXC_FAULT {10'd50, 6'd4, 6'd7}
`define CIT_EXC_INT {10'd44, 6'd5, 6'd3}
`define CIT_EXC_OTHER {10'd34, 6'd4, 6'd3}

`endif

// File: rtl/cit_pkg.sv
// Types shared by the instruction timing sequencer
package cit_pkg;

    typedef struct packed {
        logic [9:0] clk;
        logic [5:0] rd;
        logic [5:0] wr;
    } cit_time_t;

    typedef enum logic [4:0] {
        OP_SHIFT = 5'h00, OP_BITOP = 5'h01, OP_BRANCH = 5'h02,
        OP_DBRANCH = 5'h03, OP_TRAP = 5'h04, OP_TRAP_ON_OVERFLOW = 5'h05,
        OP_CHK = 5'h06, OP_JMP = 5'h07, OP_JSR = 5'h08, OP_LEA = 5'h09,
        OP_PEA = 5'h0a, OP_MULTI_REGISTER_MOVE = 5'h0b, OP_XARITH = 5'h0c,
        OP_DECIMAL = 5'h0d, OP_RESET = 5'h0e, OP_STOP = 5'h0f,
        OP_RTE = 5'h10, OP_RTR = 5'h11, OP_CSET = 5'h12, OP_TAS = 5'h13,
        OP_EXC_RESET = 5'h14, OP_EXC_FAULT = 5'h15, OP_EXC_INT = 5'h16,
        OP_EXC_OTHER = 5'h17
    } cit_op_t;

    typedef enum logic [3:0] {
        EA_DREG = 4'h0, EA_AREG = 4'h1, EA_IND = 4'h2, EA_POSTINC = 4'h3,
        EA_PREDEC = 4'h4, EA_DISP = 4'h5, EA_INDEX = 4'h6, EA_ABSW = 4'h7,
        EA_ABSL = 4'h8, EA_PCDISP = 4'h9, EA_PCINDEX = 4'ha, EA_IMM = 4'hb
    } cit_ea_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUS = 3'b010,
        ST_INT = 3'b100
    } cit_state_t;

endpackage : cit_pkg

// File: rtl/cit_timer.sv
// Instruction timing sequencer: paces bus and internal clocks per instruction
//
// How it works
// [RL1] Each bus read or write lasts four clocks; wait states add clocks.
// [RL2] Exactly the listed number of reads and writes is issued, unless a bus error ends the run early.
// [RL3] Marked instructions add operand-address clocks and reads, never writes.
// [RL4] Register shift: 6+2n byte/word, 8+2n long, one read.
// [RL5] Memory bit op 8(1/1) dynamic, 12(2/1) static; register clear 10 dynamic, 14 static.
// [RL6] Branch taken 10(2/0); not taken 8(1/0) byte, 12(2/0) word.
// [RL7] Decrement-branch: true 12, loop 10, expired 14 with three reads.
// [RL8] Trap 34(4/3); overflow trap 34 or 4; bounds 40 or 10.
// [RL9] Indirect jump 8, subroutine 16(2/2), load 4, push 12(1/2).
// [RL10] Multi-register move adds 4n word, 8n long; base 12 or 8.
// [RL11] Extended arith 4/8 reg, 18/30 memory; decimal 6 or 18.
// [RL12] External reset 132(1/0), stop 4(0/0), exception return 20(5/0).
// [RL13] Conditional set 4 false, 6 true; test-and-set 4 or 10(1/1).
// [RL14] Exceptions: reset 34(6/0), faults 50(4/7), interrupt 44(5/3).
// [RL15] Interrupt figure assumes four-clock acknowledge; longer adds clocks.
// [RL16] Indexed modes cost the same for word or long index.
// [RL17] Returns load PC only at fourth bus cycle; earlier errors keep PC.
// [RL18] Clock, read and write counters are visible per instruction.
`include "cit_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cit_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Instruction request
    input wire logic start,
    input wire logic [4:0] opClass,
    input wire logic [3:0] eaMode,
    input wire logic longSize,
    input wire logic memOperand,
    input wire logic flagA,
    input wire logic flagB,
    input wire logic [5:0] countN,
    // System bus pins
    input wire logic memWait,
    input wire logic busErr,
    output logic busRead,
    output logic busWrite,
    // Status
    output logic busy,
    output logic done,
    output logic fault,
    output logic pcLoad,
    output logic [11:0] cycleCount,
    output logic [5:0] readCount,
    output logic [5:0] writeCount
);

    // ****************************************
    // Timing arithmetic
    // ****************************************
    function automatic cit_pkg::cit_time_t addT(input cit_pkg::cit_time_t a,
                                               input cit_pkg::cit_time_t b);
        addT.clk = a.clk + b.clk;
        addT.rd = a.rd + b.rd;
        addT.wr = a.wr + b.wr;
    endfunction : addT

    // Index size never enters the figure
    function automatic cit_pkg::cit_time_t eaTime(input logic [3:0] m,
                                                 input logic lng);
        cit_pkg::cit_time_t t;
        t = `CIT_ZERO;
        case (cit_pkg::cit_ea_t'(m))
            cit_pkg::EA_IND, cit_pkg::EA_POSTINC, cit_pkg::EA_IMM:
                t = `CIT_EA_IND;
            cit_pkg::EA_PREDEC: t = `CIT_EA_PREDEC;
            cit_pkg::EA_DISP, cit_pkg::EA_ABSW, cit_pkg::EA_PCDISP:
                t = `CIT_EA_DISP;
            cit_pkg::EA_INDEX, cit_pkg::EA_PCINDEX: t = `CIT_EA_INDEX; // RL16
            cit_pkg::EA_ABSL: t = `CIT_EA_ABSL;
            default: t = `CIT_ZERO;
        endcase
        if (lng && t.clk != 10'd0) begin
            t = addT(t, `CIT_EA_LONG_EXTRA);
        end
        eaTime = t;
    endfunction : eaTime

    function automatic cit_pkg::cit_time_t opTime(input logic [4:0] op,
        input logic lng, input logic mem, input logic fa, input logic fb,
        input logic [5:0] n);
        cit_pkg::cit_time_t t;
        logic useEa;
        t = `CIT_ZERO;
        useEa = 1'b0;
        case (cit_pkg::cit_op_t'(op))
            cit_pkg::OP_SHIFT: begin
                if (mem) begin
                    t = `CIT_SHIFT_MEM;
                    useEa = 1'b1;
                end else begin
                    t = lng ? `CIT_SHIFT_L : `CIT_SHIFT_BW; // RL4
                    t.clk = t.clk + {3'h0, n, 1'b0}; // RL4
                end
            end
            cit_pkg::OP_BITOP: begin
                // flagA static form, flagB clear operation
                if (mem) begin
                    t = fa ? `CIT_BIT_STAT_MEM : `CIT_BIT_DYN_MEM; // RL5
                    useEa = 1'b1;
                end else if (fb) begin
                    t = fa ? `CIT_BIT_CLEAR_STAT_REG : `CIT_BIT_CLEAR_DYN_REG; // RL5
                end else begin
                    t = fa ? `CIT_BIT_STAT_REG : `CIT_BIT_DYN_REG;
                end
            end
            cit_pkg::OP_BRANCH: t = fa ? `CIT_BR_TAKEN
                : (fb ? `CIT_BR_WORD_NOT : `CIT_BR_BYTE_NOT); // RL6
            cit_pkg::OP_DBRANCH: t = fa ? `CIT_DB_TRUE
                : (fb ? `CIT_DB_EXPIRED : `CIT_DB_LOOP); // RL7
            cit_pkg::OP_TRAP: t = `CIT_TRAP; // RL8
            cit_pkg::OP_TRAP_ON_OVERFLOW: t = fa ? `CIT_TRAP_ON_OVERFLOW_TRAP : `CIT_TRAP_ON_OVERFLOW_PASS; // RL8
            cit_pkg::OP_CHK: begin
                t = fa ? `CIT_CHK_TRAP : `CIT_CHK_PASS; // RL8
                useEa = 1'b1;
            end
            cit_pkg::OP_JMP: t = `CIT_JMP; // RL9
            cit_pkg::OP_JSR: t = `CIT_JSR; // RL9
            cit_pkg::OP_LEA: t = `CIT_LEA; // RL9
            cit_pkg::OP_PEA: t = `CIT_PEA; // RL9
            cit_pkg::OP_MULTI_REGISTER_MOVE: begin
                // flagA means registers to memory
                t = fa ? `CIT_MULTI_REGISTER_MOVE_TO_MEM : `CIT_MULTI_REGISTER_MOVE_TO_REG; // RL10
                t.clk = t.clk + (lng ? {1'h0, n, 3'h0} : {2'h0, n, 2'h0});
                if (fa) t.wr = lng ? {n[4:0], 1'b0} : n; // RL10
                else t.rd = t.rd + (lng ? {n[4:0], 1'b0} : n); // RL10
            end
            cit_pkg::OP_XARITH: begin
                if (mem) t = lng ? `CIT_XARITH_MEM_L : `CIT_XARITH_MEM_BW;
                else t = lng ? `CIT_XARITH_REG_L : `CIT_XARITH_REG_BW; // RL11
            end
            cit_pkg::OP_DECIMAL: t = mem ? `CIT_DEC_MEM : `CIT_DEC_REG; // RL11
            cit_pkg::OP_RESET: t = `CIT_RESET_INS; // RL12
            cit_pkg::OP_STOP: t = `CIT_STOP; // RL12
            cit_pkg::OP_RTE, cit_pkg::OP_RTR: t = `CIT_RETURN; // RL12
            cit_pkg::OP_CSET: begin
                t = fa ? `CIT_CSET_TRUE : `CIT_CSET_FALSE; // RL13
                if (mem) t = `CIT_CSET_MEM; // RL13
                useEa = mem;
            end
            cit_pkg::OP_TAS: begin
                t = mem ? `CIT_TAS_MEM : `CIT_TAS_REG; // RL13
                useEa = mem;
            end
            cit_pkg::OP_EXC_RESET: t = `CIT_EXC_RESET; // RL14
            cit_pkg::OP_EXC_FAULT: t = `CIT_EXC_FAULT; // RL14
            cit_pkg::OP_EXC_INT: t = `CIT_EXC_INT; // RL14
            cit_pkg::OP_EXC_OTHER: t = `CIT_EXC_OTHER; // RL14
            default: t = `CIT_STOP;
        endcase
        // Operand address is charged a long extra when the operation is long and the mode costs clocks
        if (useEa) t = addT(t, eaTime(eaMode, lng)); // RL3
        opTime = t;
    endfunction : opTime

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic waitMeta, waitSync, errMeta, errSync;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            waitMeta <= 1'b0;
            waitSync <= 1'b0;
            errMeta <= 1'b0;
            errSync <= 1'b0;
        end else begin
            waitMeta <= memWait;
            waitSync <= waitMeta;
            errMeta <= busErr;
            errSync <= errMeta;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    cit_pkg::cit_state_t state;
    cit_pkg::cit_time_t reqTime;
    logic [1:0] phase;
    logic [5:0] rdLeft, wrLeft;
    logic [9:0] intLeft;
    logic isReturn;
    logic busEnd, lastBus;
    logic [6:0] busDoneCount;

    assign reqTime = opTime(opClass, longSize, memOperand, flagA, flagB,
                            countN);
    // A wait state holds the last clock of the cycle
    assign busEnd = (state == cit_pkg::ST_BUS) && (phase == `CIT_BUS_CLKS)
                    && !waitSync; // RL1 RL15
    assign lastBus = (rdLeft + wrLeft) == 6'h01;
    assign busDoneCount = {1'b0, readCount} + {1'b0, writeCount};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= cit_pkg::ST_IDLE;
            phase <= 2'h0;
            rdLeft <= 6'h00;
            wrLeft <= 6'h00;
            intLeft <= 10'h000;
            isReturn <= 1'b0;
            busRead <= 1'b0;
            busWrite <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            fault <= 1'b0;
            pcLoad <= 1'b0;
        end else begin
            done <= 1'b0;
            fault <= 1'b0;
            pcLoad <= 1'b0;
            unique case (state)
                cit_pkg::ST_IDLE: begin
                    if (start) begin
                        rdLeft <= reqTime.rd; // RL2
                        wrLeft <= reqTime.wr; // RL2
                        intLeft <= reqTime.clk - 10'({reqTime.rd, 2'h0})
                                   - 10'({reqTime.wr, 2'h0});
                        isReturn <= opClass == 5'(cit_pkg::OP_RTE) ||
                                    opClass == 5'(cit_pkg::OP_RTR);
                        phase <= 2'h0;
                        busy <= 1'b1;
                        busRead <= reqTime.rd != 6'h00;
                        busWrite <= reqTime.rd == 6'h00 && reqTime.wr != 6'h00;
                        state <= (reqTime.rd != 6'h00 || reqTime.wr != 6'h00)
                                 ? cit_pkg::ST_BUS : cit_pkg::ST_INT;
                    end
                end
                cit_pkg::ST_BUS: begin
                    if (!(phase == `CIT_BUS_CLKS && waitSync)) begin
                        phase <= phase + 2'h1;
                    end
                    if (busEnd) begin
                        if (rdLeft != 6'h00) rdLeft <= rdLeft - 6'h01;
                        else wrLeft <= wrLeft - 6'h01;
                        if (errSync) begin
                            // Abort with no PC load; on a return's fifth read the PC was already loaded at the fourth
                            state <= cit_pkg::ST_IDLE; // RL17
                            busRead <= 1'b0;
                            busWrite <= 1'b0;
                            busy <= 1'b0;
                            done <= 1'b1;
                            fault <= 1'b1;
                        end else begin
                            pcLoad <= isReturn &&
                                      busDoneCount == `CIT_RETURN_PC_CYCLE;
                            busRead <= rdLeft > 6'h01;
                            busWrite <= !lastBus && rdLeft <= 6'h01;
                            if (lastBus && intLeft == 10'h000) begin
                                state <= cit_pkg::ST_IDLE;
                                busy <= 1'b0;
                                done <= 1'b1;
                            end else if (lastBus) begin
                                state <= cit_pkg::ST_INT;
                            end
                        end
                    end
                end
                cit_pkg::ST_INT: begin
                    intLeft <= intLeft - 10'h001;
                    if (intLeft <= 10'h001) begin
                        state <= cit_pkg::ST_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Observation counters
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cycleCount <= 12'h000;
            readCount <= 6'h00;
            writeCount <= 6'h00;
        end else if (state == cit_pkg::ST_IDLE) begin
            if (start) begin
                cycleCount <= 12'h000;
                readCount <= 6'h00;
                writeCount <= 6'h00;
            end
        end else begin
            cycleCount <= cycleCount + 12'h001; // RL18
            if (busEnd && rdLeft != 6'h00) readCount <= readCount + 6'h01;
            if (busEnd && rdLeft == 6'h00) writeCount <= writeCount + 6'h01;
        end
    end

endmodule : cit_timer
`default_nettype wire

// File: tb/cit_timer_asserts.sv
// Port-level assertions for the instruction timing sequencer
`timescale 1ns/1ps
`default_nettype none

module cit_timer_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Request and bus
    input wire logic start,
    input wire logic busRead,
    input wire logic busWrite,
    // Status
    input wire logic busy,
    input wire logic done,
    input wire logic fault,
    input wire logic pcLoad,
    input wire logic [11:0] cycleCount,
    input wire logic [5:0] readCount,
    input wire logic [5:0] writeCount
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // ****************************************
    // Instruction run
    // ****************************************
    sequence s_take;
        start && !busy;
    endsequence
    sequence s_run;
        busy [*4];
    endsequence

    property p_take;
        s_take |=> s_run;
    endproperty
    a_take: assert property (p_take) else $error("run too short");
    property p_clear;
        s_take |=> readCount == 6'h00 && writeCount == 6'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("counts not clear");
    property p_read4;
        $rose(busRead) |-> busRead [*4];
    endproperty
    a_read4: assert property (p_read4) else $error("short read");
    property p_excl;
        busRead |-> !busWrite;
    endproperty
    a_excl: assert property (p_excl) else $error("read and write");
    // Read count moves only upwards by one, apart from the clear at a take
    property p_step;
        $changed(readCount) && !$rose(busy) |->
            readCount == $past(readCount) + 6'h01;
    endproperty
    a_step: assert property (p_step) else $error("read count jump");
    property p_done;
        $fell(busy) |-> done ##1 !done;
    endproperty
    a_done: assert property (p_done) else $error("bad done pulse");
    property p_fault;
        fault |-> done && !busy;
    endproperty
    a_fault: assert property (p_fault) else $error("lone fault");
    property p_pcLoad;
        pcLoad |-> busy && !fault && readCount == 6'h04;
    endproperty
    a_pcLoad: assert property (p_pcLoad) else $error("early load");
    property p_hold;
        !busy && !start |=> $stable(cycleCount) && $stable(readCount);
    endproperty
    a_hold: assert property (p_hold) else $error("counts moved");
endmodule : cit_timer_asserts

bind cit_timer cit_timer_asserts u_chk (
    .mclk(mclk), .arst_n(arst_n), .start(start), .busRead(busRead),
    .busWrite(busWrite), .busy(busy), .done(done), .fault(fault),
    .pcLoad(pcLoad), .cycleCount(cycleCount), .readCount(readCount),
    .writeCount(writeCount)
);

`default_nettype wire

// File: tb/cit_mem_model.sv
// Memory and peripheral model on the far side of the system bus
`timescale 1ns/1ps
`default_nettype none

module cit_mem_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Bus cycles from the core
    input wire logic busRead,
    input wire logic busWrite,
    // Behaviour chosen by the bench
    input wire logic slow,
    input wire logic [2:0] errAt,
    // Answers to the core
    output logic memWait,
    output logic busErr
);
    logic [7:0] busClk;

    // Reads and writes run back to back, so one count spans them all
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busClk <= 8'h00;
        end else if (busRead || busWrite) begin
            busClk <= busClk + 8'h01;
        end else begin
            busClk <= 8'h00;
        end
    end

    // Slow device holds off its first cycle, acknowledge included
    assign memWait = slow && (busRead || busWrite) &&
        busClk < 8'h04;
    // Cycle index only valid without wait states
    assign busErr = errAt != 3'h0 && (busRead || busWrite) &&
        busClk[7:2] == {3'h0, errAt - 3'h1};
endmodule : cit_mem_model

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the instruction timing sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic mclk, arst_n, start, longSize, memOperand, flagA, flagB, slow;
    logic [4:0] opClass;
    logic [3:0] eaMode;
    logic [5:0] countN, readCount, writeCount;
    logic memWait, busErr, busRead, busWrite, busy, done, fault, pcLoad;
    logic [11:0] cycleCount;
    logic [2:0] errAt;
    integer fail_count = 0;
    integer comparisons = 0;
    integer seed = 32'hfead;
    integer ticks = 0;
    integer n, k, bus, pcl;

    cit_timer dut (
        .mclk(mclk), .arst_n(arst_n), .start(start), .opClass(opClass),
        .eaMode(eaMode), .longSize(longSize), .memOperand(memOperand),
        .flagA(flagA), .flagB(flagB), .countN(countN), .memWait(memWait),
        .busErr(busErr), .busRead(busRead), .busWrite(busWrite), .busy(busy),
        .done(done), .fault(fault), .pcLoad(pcLoad), .cycleCount(cycleCount),
        .readCount(readCount), .writeCount(writeCount)
    );
    cit_mem_model mem (
        .mclk(mclk), .arst_n(arst_n), .busRead(busRead), .busWrite(busWrite),
        .slow(slow), .errAt(errAt), .memWait(memWait), .busErr(busErr)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check

    task end_of_test;
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // One instruction; garbage requests while busy must be ignored
    task automatic run(input logic [4:0] op, input logic [3:0] ea,
            input logic [3:0] f, input integer cn);
        integer lim;
        lim = 0;
        bus = 0;
        pcl = 0;
        opClass = op;
        eaMode = ea;
        {longSize, memOperand, flagA, flagB} = f;
        countN = cn[5:0];
        start = 1'b1;
        @(posedge mclk);
        #1;
        while (done !== 1'b1 && lim < 400) begin
            bus = bus + int'(busRead === 1'b1 || busWrite === 1'b1);
            pcl = pcl + int'(pcLoad === 1'b1);
            start = 1'($random(seed));
            opClass = 5'($random(seed));
            @(posedge mclk);
            #1;
            lim = lim + 1;
        end
        pcl = pcl + int'(pcLoad === 1'b1);
        check(done, 1'b1);
    endtask : run

    // Wait states show as bus clocks beyond four per cycle
    task automatic tc(input logic [4:0] op, input logic [3:0] ea,
            input logic [3:0] f, input integer cn, input integer t,
            input integer r, input integer w);
        run(op, ea, f, cn);
        check(fault, 1'b0);
        check(readCount, r);
        check(writeCount, w);
        check(bus, 4 * (r + w) + ((slow && r + w > 0) ? 3 : 0));
        check(cycleCount, t + bus - 4 * (r + w));
    endtask : tc

    // Flags are {longSize, memOperand, flagA, flagB}
    task automatic all_cases;
        n = $unsigned($random(seed)) % 64;
        tc(5'h00, 4'h0, 4'b0000, n, 6 + 2 * n, 1, 0);
        tc(5'h00, 4'h0, 4'b1000, n, 8 + 2 * n, 1, 0);
        tc(5'h01, 4'h2, 4'b0100, 0, 12, 2, 1);
        tc(5'h01, 4'h8, 4'b0110, 0, 24, 5, 1);
        tc(5'h01, 4'h0, 4'b0001, 0, 10, 1, 0);
        tc(5'h01, 4'h0, 4'b0010, 0, 12, 2, 0);
        tc(5'h01, 4'h0, 4'b0011, 0, 14, 2, 0);
        tc(5'h01, 4'h9, 4'b0100, 0, 16, 3, 1);
        tc(5'h00, 4'h4, 4'b0100, 0, 14, 2, 1);
        tc(5'h06, 4'h7, 4'b0000, 0, 18, 3, 0);
        tc(5'h06, 4'hb, 4'b0000, 0, 14, 2, 0);
        tc(5'h12, 4'h5, 4'b0100, 0, 16, 3, 1);
        tc(5'h13, 4'h3, 4'b0100, 0, 14, 2, 1);
        tc(5'h02, 4'h0, 4'b0010, 0, 10, 2, 0);
        tc(5'h02, 4'h0, 4'b0000, 0, 8, 1, 0);
        tc(5'h02, 4'h0, 4'b0001, 0, 12, 2, 0);
        tc(5'h03, 4'h0, 4'b0010, 0, 12, 2, 0);
        tc(5'h03, 4'h0, 4'b0000, 0, 10, 2, 0);
        tc(5'h03, 4'h0, 4'b0001, 0, 14, 3, 0);
        tc(5'h04, 4'h0, 4'b0000, 0, 34, 4, 3);
        tc(5'h05, 4'h0, 4'b0010, 0, 34, 5, 3);
        tc(5'h05, 4'h0, 4'b0000, 0, 4, 1, 0);
        tc(5'h06, 4'h0, 4'b0010, 0, 40, 5, 3);
        tc(5'h06, 4'h6, 4'b0000, 0, 20, 3, 0);
        tc(5'h06, 4'ha, 4'b0000, 0, 20, 3, 0);
        tc(5'h07, 4'h2, 4'b0000, 0, 8, 2, 0);
        tc(5'h08, 4'h2, 4'b0000, 0, 16, 2, 2);
        tc(5'h09, 4'h2, 4'b0000, 0, 4, 1, 0);
        tc(5'h0a, 4'h2, 4'b0000, 0, 12, 1, 2);
        n = 1 + $unsigned($random(seed)) % 16;
        tc(5'h0b, 4'h2, 4'b0000, n, 12 + 4 * n, 3 + n, 0);
        tc(5'h0b, 4'h2, 4'b1000, n, 12 + 8 * n, 3 + 2 * n, 0);
        tc(5'h0b, 4'h2, 4'b0010, n, 8 + 4 * n, 2, n);
        tc(5'h0b, 4'h2, 4'b1010, n, 8 + 8 * n, 2, 2 * n);
        tc(5'h0c, 4'h0, 4'b0000, 0, 4, 1, 0);
        tc(5'h0c, 4'h0, 4'b1000, 0, 8, 1, 0);
        tc(5'h0c, 4'h0, 4'b0100, 0, 18, 3, 1);
        tc(5'h0c, 4'h0, 4'b1100, 0, 30, 5, 2);
        tc(5'h0d, 4'h0, 4'b0000, 0, 6, 1, 0);
        tc(5'h0d, 4'h0, 4'b0100, 0, 18, 3, 1);
        tc(5'h0e, 4'h0, 4'b0000, 0, 132, 1, 0);
        tc(5'h0f, 4'h0, 4'b0000, 0, 4, 0, 0);
        tc(5'h10, 4'h0, 4'b0000, 0, 20, 5, 0);
        tc(5'h11, 4'h0, 4'b0000, 0, 20, 5, 0);
        tc(5'h12, 4'h0, 4'b0000, 0, 4, 1, 0);
        tc(5'h12, 4'h0, 4'b0010, 0, 6, 1, 0);
        tc(5'h13, 4'h0, 4'b0000, 0, 4, 1, 0);
        tc(5'h13, 4'h2, 4'b0100, 0, 14, 2, 1);
        tc(5'h14, 4'h0, 4'b0000, 0, 34, 6, 0);
        tc(5'h15, 4'h0, 4'b0000, 0, 50, 4, 7);
        tc(5'h16, 4'h0, 4'b0000, 0, 44, 5, 3);
        tc(5'h17, 4'h0, 4'b0000, 0, 34, 4, 3);
    endtask : all_cases

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        ticks = ticks + 1;
        if (ticks == 12000) begin
            fail_count = fail_count + 1;
            end_of_test();
        end
    end

    initial begin
        arst_n = 1'b0;
        start = 1'b0;
        opClass = 5'h00;
        eaMode = 4'h0;
        {longSize, memOperand, flagA, flagB} = 4'h0;
        countN = 6'h00;
        slow = 1'b0;
        errAt = 3'h0;
        repeat (12) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        @(posedge mclk);
        #1;
        check({busy, done, busRead, busWrite, cycleCount}, 16'h0000);
        for (k = 0; k < 2; k = k + 1) begin
            slow = k[0];
            all_cases();
        end
        slow = 1'b0;
        // Bus error on each of the return's five reads
        for (k = 0; k < 12; k = k + 1) begin
            errAt = 3'(k % 6);
            run(k < 6 ? 5'h10 : 5'h11, 4'h0, 4'h0, 0);
            check(fault, errAt != 3'h0);
            check(pcl, errAt == 3'h0 || errAt == 3'h5);
        end
        errAt = 3'h0;
        start = 1'b1;
        opClass = 5'h0e;
        @(posedge mclk);
        #1;
        start = 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        arst_n = 1'b0;
        #1;
        check({busy, busRead, cycleCount}, 14'h0000);
        @(posedge mclk);
        #1;
        arst_n = 1'b1;
        tc(5'h0f, 4'h0, 4'b0000, 0, 4, 0, 0);
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
